// *** pkg/scrb_pkg.sv ***
// Package of the serial configuration register bank: offsets, layouts, resets, timing.
// Assumes a 10 MHz system clock and a 15-bit serial register address.
`default_nettype none

package scrb_pkg;

  // ==========================================================================
  // Serial frame layout
  localparam int              ADDR_W      = 15;
  localparam logic [4:0]      INSTR_LAST  = 5'h0f;
  localparam logic [4:0]      BYTE_LAST   = 5'h07;
  localparam logic [14:0]     ADDR_STEP   = 15'h0001;

  // ==========================================================================
  // Register offsets
  localparam logic [14:0]     OFS_CFG     = 15'h0000;
  localparam logic [14:0]     OFS_MODE    = 15'h0002;
  localparam logic [14:0]     OFS_TYPE    = 15'h0003;
  localparam logic [14:0]     OFS_PART_LO = 15'h0004;
  localparam logic [14:0]     OFS_PART_HI = 15'h0005;
  localparam logic [14:0]     OFS_MAKR_LO = 15'h000c;
  localparam logic [14:0]     OFS_MAKR_HI = 15'h000d;
  localparam logic [14:0]     OFS_USR     = 15'h0010;
  localparam logic [14:0]     OFS_CLKC    = 15'h0029;

  // ==========================================================================
  // Field positions
  localparam int              CFG_SOFT_RST = 7;
  localparam int              CFG_ASCEND   = 5;
  localparam int              CFG_RD_LINE  = 4;
  localparam int              USR_HOLD     = 0;
  localparam int              CLKC_PROC    = 6;
  localparam int              CLKC_RECV    = 5;
  localparam int              CLKC_ZOOM    = 4;
  localparam logic [1:0]      MODE_NORMAL  = 2'h0;
  localparam logic [1:0]      MODE_PDOWN   = 2'h3;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]      CFG_RST     = 8'h30;
  localparam logic [7:0]      MODE_RST    = 8'h00;
  localparam logic [3:0]      TYPE_HI_RST = 4'h0;
  localparam logic [7:0]      USR_RST     = 8'h00;
  localparam logic [7:0]      CLKC_RST    = 8'h00;

  // ==========================================================================
  // Timing: soft reset busy time, longest time so rounded down
  localparam int              CLK_NS       = 100;
  localparam int              SOFT_RST_NS  = 750;
  localparam int              SOFT_RST_CYC = SOFT_RST_NS / CLK_NS;
  localparam logic [3:0]      SOFT_RST_LD  = 4'(SOFT_RST_CYC - 1);

  // ==========================================================================
  // Serial engine states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_INSTR = 4'h2,
    ST_DATA  = 4'h4,
    ST_RST   = 4'h8
  } scrb_state_t;

endpackage

`default_nettype wire

// *** logic/scrb_sync.sv ***
// Two-stage synchroniser for pin inputs, one per bit.
// Assumes the inputs are asynchronous to clk and change slowly against it.
`default_nettype none

module scrb_sync #(
  parameter int W = 1
) (
  // Clock
  input  wire logic         clk,
  // Data
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // ==========================================================================
  // First stage feeds only the second
  always_ff @(posedge clk) begin
    meta_q <= din;
    dout   <= meta_q;
  end

endmodule

`default_nettype wire

// *** logic/scrb_top.sv ***
// Serial configuration register bank with its serial slave engine.
// Assumes serial clock well below clk/4; pins are sampled through two flip-flops.
`default_nettype none

module scrb_top #(
  parameter logic [3:0]  TYPE_CODE = 4'h5,      // Arbitrary value
  parameter logic [15:0] PART_CODE = 16'h00a5,  // Arbitrary value
  parameter logic [15:0] MAKR_CODE = 16'h005a   // Arbitrary value
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Serial pins
  input  wire logic       cs_n_pin,
  input  wire logic       sclk_pin,
  input  wire logic       sdi_pin,
  output var  logic       sdo,
  output var  logic       sdo_oe,
  // Device controls
  output logic      [1:0] op_mode,
  output var  logic       power_down,
  output var  logic       chip_reset,
  output logic            alignment_processor_enable,
  output logic            alignment_receiver_enable,
  output logic            alignment_window_zoom,
  output logic      [3:0] alignment_delay_select
);

  // ==========================================================================
  // Pin synchronisers
  logic                  cs_n_s;
  logic                  sclk_s;
  logic                  sdi_s;

  scrb_sync #(.W(3)) u_sync (
    .clk  (clk),
    .din  ({cs_n_pin, sclk_pin, sdi_pin}),
    .dout ({cs_n_s, sclk_s, sdi_s})
  );

  // ==========================================================================
  // State
  scrb_pkg::scrb_state_t state_q, state_d;
  logic            [4:0] bit_q, bit_d;
  logic           [14:0] shift_q, shift_d;
  logic           [14:0] addr_q, addr_d;
  logic                  rw_q, rw_d;
  logic            [7:0] tx_q, tx_d;
  logic                  sdo_d, sdo_oe_d;
  logic                  sclk_q, cs_n_q;
  logic            [3:0] rst_cnt_q, rst_cnt_d;
  logic                  rst_busy_d;
  logic                  pd_d;
  logic            [7:0] cfg_q, cfg_d;
  logic            [7:0] mode_q, mode_d;
  logic            [3:0] type_hi_q, type_hi_d;
  logic            [7:0] usr_q, usr_d;
  logic            [7:0] clkc_q, clkc_d;

  logic                  sclk_rise, sclk_fall, cs_fall;
  logic                  wr_en, byte_done;
  logic            [7:0] wr_data;
  logic           [14:0] next_addr;
  logic           [14:0] instr_addr;

  assign sclk_rise  = sclk_s & ~sclk_q;
  assign sclk_fall  = ~sclk_s & sclk_q;
  assign cs_fall    = cs_n_q & ~cs_n_s;
  assign wr_data    = {shift_q[6:0], sdi_s};
  assign instr_addr = {shift_q[13:0], sdi_s};
  assign byte_done  = (state_q == scrb_pkg::ST_DATA) && !cs_n_s && sclk_rise
                      && (bit_q == scrb_pkg::BYTE_LAST);

  // Streaming address step
  always_comb begin
    if (usr_q[scrb_pkg::USR_HOLD]) begin
      next_addr = addr_q;
    end else if (cfg_q[scrb_pkg::CFG_ASCEND]) begin
      next_addr = addr_q + scrb_pkg::ADDR_STEP;
    end else begin
      next_addr = addr_q - scrb_pkg::ADDR_STEP;
    end
  end

  // ==========================================================================
  // Read data; soft reset bit never reads back set
  function automatic logic [7:0] rd_byte(input logic [14:0] a);
    case (a)
      scrb_pkg::OFS_CFG:     rd_byte = {1'b0, cfg_q[6:5], 1'b1, cfg_q[3:0]};
      scrb_pkg::OFS_MODE:    rd_byte = mode_q;
      scrb_pkg::OFS_TYPE:    rd_byte = {type_hi_q, TYPE_CODE};
      scrb_pkg::OFS_PART_LO: rd_byte = PART_CODE[7:0];
      scrb_pkg::OFS_PART_HI: rd_byte = PART_CODE[15:8];
      scrb_pkg::OFS_MAKR_LO: rd_byte = MAKR_CODE[7:0];
      scrb_pkg::OFS_MAKR_HI: rd_byte = MAKR_CODE[15:8];
      scrb_pkg::OFS_USR:     rd_byte = usr_q;
      scrb_pkg::OFS_CLKC:    rd_byte = clkc_q;
      default:               rd_byte = 8'h00;
    endcase
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    state_d   = state_q;
    bit_d     = bit_q;
    shift_d   = shift_q;
    addr_d    = addr_q;
    rw_d      = rw_q;
    tx_d      = tx_q;
    sdo_d     = sdo;
    sdo_oe_d  = 1'b0;
    rst_cnt_d = rst_cnt_q;
    cfg_d     = cfg_q;
    mode_d    = mode_q;
    type_hi_d = type_hi_q;
    usr_d     = usr_q;
    clkc_d    = clkc_q;
    wr_en     = 1'b0;
    case (state_q)
      scrb_pkg::ST_IDLE: begin
        // Only a fresh select starts a frame, so a frame cut by soft reset is dropped
        if (cs_fall) begin
          state_d = scrb_pkg::ST_INSTR;
          bit_d   = 5'h00;
        end
      end
      scrb_pkg::ST_INSTR: begin
        if (cs_n_s) begin
          state_d = scrb_pkg::ST_IDLE;
        end else if (sclk_rise) begin
          shift_d = {shift_q[13:0], sdi_s};
          bit_d   = bit_q + 5'h01;
          if (bit_q == scrb_pkg::INSTR_LAST) begin
            rw_d    = shift_q[14];
            addr_d  = instr_addr;
            tx_d    = rd_byte(instr_addr);
            bit_d   = 5'h00;
            state_d = scrb_pkg::ST_DATA;
          end
        end
      end
      scrb_pkg::ST_DATA: begin
        if (cs_n_s) begin
          state_d = scrb_pkg::ST_IDLE;
        end else begin
          sdo_oe_d = rw_q;
          if (sclk_fall) begin
            sdo_d = tx_q[7];
            tx_d  = {tx_q[6:0], 1'b0};
          end
          if (sclk_rise) begin
            shift_d = {shift_q[13:0], sdi_s};
            bit_d   = bit_q + 5'h01;
          end
          if (byte_done) begin
            bit_d  = 5'h00;
            wr_en  = !rw_q;
            addr_d = next_addr;
            tx_d   = rd_byte(next_addr);
          end
        end
      end
      scrb_pkg::ST_RST: begin
        // Whole bank held at reset values while the device settles
        cfg_d     = scrb_pkg::CFG_RST;
        mode_d    = scrb_pkg::MODE_RST;
        type_hi_d = scrb_pkg::TYPE_HI_RST;
        usr_d     = scrb_pkg::USR_RST;
        clkc_d    = scrb_pkg::CLKC_RST;
        if (rst_cnt_q == 4'h0) begin
          state_d = scrb_pkg::ST_IDLE;
        end else begin
          rst_cnt_d = rst_cnt_q - 4'h1;
        end
      end
      default: begin
        state_d = scrb_pkg::ST_IDLE;
      end
    endcase
    if (wr_en) begin
      case (addr_q)
        scrb_pkg::OFS_CFG: begin
          // Soft reset is not stored; marker forced, so writes cannot clear it
          cfg_d = {1'b0, wr_data[6:5], 1'b1, wr_data[3:0]};
          if (wr_data[scrb_pkg::CFG_SOFT_RST]) begin
            state_d   = scrb_pkg::ST_RST;
            rst_cnt_d = scrb_pkg::SOFT_RST_LD;
          end
        end
        scrb_pkg::OFS_MODE: mode_d    = wr_data;
        scrb_pkg::OFS_TYPE: type_hi_d = wr_data[7:4];
        scrb_pkg::OFS_USR:  usr_d     = wr_data;
        scrb_pkg::OFS_CLKC: clkc_d    = wr_data;
        default: ;
      endcase
    end
    rst_busy_d = (state_d == scrb_pkg::ST_RST);
    pd_d       = (mode_d[1:0] == scrb_pkg::MODE_PDOWN);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q    <= scrb_pkg::ST_IDLE;
      bit_q      <= 5'h00;
      shift_q    <= 15'h0000;
      addr_q     <= 15'h0000;
      rw_q       <= 1'b0;
      tx_q       <= 8'h00;
      sdo        <= 1'b0;
      sdo_oe     <= 1'b0;
      sclk_q     <= 1'b0;
      cs_n_q     <= 1'b1;
      rst_cnt_q  <= 4'h0;
      chip_reset <= 1'b0;
      power_down <= 1'b0;
      cfg_q      <= scrb_pkg::CFG_RST;
      mode_q     <= scrb_pkg::MODE_RST;
      type_hi_q  <= scrb_pkg::TYPE_HI_RST;
      usr_q      <= scrb_pkg::USR_RST;
      clkc_q     <= scrb_pkg::CLKC_RST;
    end else begin
      state_q    <= state_d;
      bit_q      <= bit_d;
      shift_q    <= shift_d;
      addr_q     <= addr_d;
      rw_q       <= rw_d;
      tx_q       <= tx_d;
      sdo        <= sdo_d;
      sdo_oe     <= sdo_oe_d;
      sclk_q     <= sclk_s;
      cs_n_q     <= cs_n_s;
      rst_cnt_q  <= rst_cnt_d;
      chip_reset <= rst_busy_d;
      power_down <= pd_d;
      cfg_q      <= cfg_d;
      mode_q     <= mode_d;
      type_hi_q  <= type_hi_d;
      usr_q      <= usr_d;
      clkc_q     <= clkc_d;
    end
  end

  assign op_mode                    = mode_q[1:0];
  assign alignment_processor_enable = clkc_q[scrb_pkg::CLKC_PROC];
  assign alignment_receiver_enable  = clkc_q[scrb_pkg::CLKC_RECV];
  assign alignment_window_zoom      = clkc_q[scrb_pkg::CLKC_ZOOM];
  assign alignment_delay_select     = clkc_q[3:0];

  // ==========================================================================
  // Checks
  // Read views as plain signals, so the checks see sampled values, not a live function
  logic            [7:0] cfg_view;
  logic            [7:0] type_view;
  logic           [15:0] part_view;
  logic           [15:0] makr_view;

  always_comb begin
    cfg_view  = rd_byte(scrb_pkg::OFS_CFG);
    type_view = rd_byte(scrb_pkg::OFS_TYPE);
    part_view = {rd_byte(scrb_pkg::OFS_PART_HI), rd_byte(scrb_pkg::OFS_PART_LO)};
    makr_view = {rd_byte(scrb_pkg::OFS_MAKR_HI), rd_byte(scrb_pkg::OFS_MAKR_LO)};
  end

  a_soft_rst_entry: assert property (@(posedge clk) disable iff (reset)
    wr_en && addr_q == scrb_pkg::OFS_CFG && wr_data[scrb_pkg::CFG_SOFT_RST]
      |=> chip_reset ##1 cfg_q == scrb_pkg::CFG_RST && usr_q == scrb_pkg::USR_RST
          && clkc_q == scrb_pkg::CLKC_RST && mode_q == scrb_pkg::MODE_RST)
    else $error("soft reset did not clear the bank");

  a_soft_rst_len: assert property (@(posedge clk) disable iff (reset)
    $rose(chip_reset) |-> chip_reset [*7] ##1 !chip_reset)
    else $error("soft reset busy time wrong");

  a_rst_read_value: assert property (@(posedge clk) disable iff (reset)
    $fell(chip_reset) |-> cfg_view == scrb_pkg::CFG_RST && !cfg_view[scrb_pkg::CFG_SOFT_RST])
    else $error("configuration does not read 0x30 after reset");

  a_addr_ascend: assert property (@(posedge clk) disable iff (reset)
    byte_done && !usr_q[scrb_pkg::USR_HOLD] && cfg_q[scrb_pkg::CFG_ASCEND]
      |=> addr_q == $past(addr_q) + scrb_pkg::ADDR_STEP)
    else $error("address did not increment");

  a_addr_descend: assert property (@(posedge clk) disable iff (reset)
    byte_done && !usr_q[scrb_pkg::USR_HOLD] && !cfg_q[scrb_pkg::CFG_ASCEND]
      |=> addr_q == $past(addr_q) - scrb_pkg::ADDR_STEP)
    else $error("address did not decrement");

  a_addr_hold: assert property (@(posedge clk) disable iff (reset)
    byte_done && usr_q[scrb_pkg::USR_HOLD] |=> $stable(addr_q))
    else $error("held address moved");

  a_sdo_read_only: assert property (@(posedge clk) disable iff (reset)
    (state_q != scrb_pkg::ST_DATA || !rw_q || cs_n_s) |=> !sdo_oe
      ##0 cfg_view[scrb_pkg::CFG_RD_LINE])
    else $error("sdo driven outside a read or marker low");

  a_pdown_mode: assert property (@(posedge clk) disable iff (reset)
    power_down == (op_mode == scrb_pkg::MODE_PDOWN))
    else $error("power down does not follow mode");

  a_type_fixed: assert property (@(posedge clk) disable iff (reset)
    wr_en && addr_q == scrb_pkg::OFS_TYPE |=> type_view[3:0] == TYPE_CODE)
    else $error("type code changed by a write");

  a_part_fixed: assert property (@(posedge clk) disable iff (reset)
    byte_done |=> part_view == PART_CODE)
    else $error("part identifier wrong");

  a_maker_fixed: assert property (@(posedge clk) disable iff (reset)
    byte_done |=> makr_view == MAKR_CODE)
    else $error("maker identifier wrong");

  a_marker_kept: assert property (@(posedge clk) disable iff (reset)
    wr_en && addr_q == scrb_pkg::OFS_CFG
      |=> cfg_q[scrb_pkg::CFG_RD_LINE] && !cfg_q[scrb_pkg::CFG_SOFT_RST])
    else $error("read-only configuration bits written");

endmodule

`default_nettype wire

// *** verif/scrb_host.sv ***
// Host model of the serial link: drives frames on the pins and samples read data.
// Assumes a mode 0 slave that samples on sclk rising and shifts out on sclk falling.
`default_nettype none

module scrb_host #(
  parameter int HALF = 6,  // Clocks per sclk phase, margin over the 2-clock sync delay
  parameter int GAP  = 4   // Clocks of cs_n high between frames
) (
  // Clock
  input  wire logic clk,
  // Serial pins
  output var  logic cs_n,
  output var  logic sclk,
  output var  logic sdi,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  // ==========================================================================
  // One frame: read flag, 15-bit address, n bytes taken from the top of wdat
  task automatic frame(input logic rd_en, input logic [14:0] adr, input int n,
                       input logic [31:0] wdat, output logic [31:0] rdat);
    logic [47:0] sh;
    sh   = {rd_en, adr, wdat};
    rdat = 32'h0000_0000;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 0; i < 16 + 8 * n; i++) begin
      sdi <= sh[47];
      sh  = {sh[46:0], 1'b0};
      repeat (HALF) @(posedge clk);
      sclk <= 1'b1;
      if (i >= 16) begin
        rdat = {rdat[30:0], sdo};
      end
      repeat (HALF) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    cs_n <= 1'b1;
    // Released data line shows the inverse, so a stale bit is never mistaken for data
    sdi  <= ~sdi;
    repeat (GAP) @(posedge clk);
  endtask

  // Silent through the soft reset busy time, with margin over 750 ns
  task automatic settle();
    repeat (12) @(posedge clk);
  endtask

endmodule

`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench of the serial configuration register bank.
// Assumes scrb_top with its pins driven by the scrb_host model.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Identity codes, values arbitrary
  localparam logic [3:0]  T_CODE = 4'h6;
  localparam logic [15:0] P_CODE = 16'h00c3;
  localparam logic [15:0] M_CODE = 16'h003c;

  logic        clk;
  logic        reset;
  logic        cs_n;
  logic        sclk;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic [1:0]  op_mode;
  logic        power_down;
  logic        chip_reset;
  logic        proc_en;
  logic        recv_en;
  logic        zoom;
  logic [3:0]  dly_sel;
  logic [31:0] rd;
  int          err_count;
  int          checked;
  int          rst_cnt = 0;
  int          oe_cnt = 0;
  int          oe_base;

  scrb_top #(.TYPE_CODE(T_CODE), .PART_CODE(P_CODE), .MAKR_CODE(M_CODE)) scrb_top_inst (
    .clk(clk), .reset(reset), .cs_n_pin(cs_n), .sclk_pin(sclk), .sdi_pin(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .op_mode(op_mode), .power_down(power_down),
    .chip_reset(chip_reset), .alignment_processor_enable(proc_en),
    .alignment_receiver_enable(recv_en), .alignment_window_zoom(zoom),
    .alignment_delay_select(dly_sel)
  );

  scrb_host scrb_host_inst (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Busy time counted independently of the frame timing
  always @(posedge clk) begin
    if (chip_reset === 1'b1) begin
      rst_cnt++;
    end
    if (sdo_oe === 1'b1) begin
      oe_cnt++;
    end
  end

  // ==========================================================================
  // Tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr1(input logic [14:0] a, input logic [7:0] d);
    scrb_host_inst.frame(1'b0, a, 1, {d, 24'h000000}, rd);
  endtask

  task automatic rdn(input logic [14:0] a, input int n);
    scrb_host_inst.frame(1'b1, a, n, 32'h0000_0000, rd);
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    close_out();
  end

  // ==========================================================================
  // Tests
  initial begin
    err_count = 0;
    checked   = 0;
    reset     = 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    // Reset values and identity codes, ascending streams
    rdn(scrb_pkg::OFS_CFG, 1);
    check(rd, 32'h0000_0030);
    check({31'h0, oe_cnt > 0}, 32'h0000_0001);
    check({31'h0, sdo_oe}, 32'h0000_0000);
    rdn(scrb_pkg::OFS_MODE, 1);
    check(rd, 32'h0000_0000);
    rdn(scrb_pkg::OFS_TYPE, 1);
    check(rd, {28'h0000000, T_CODE});
    rdn(scrb_pkg::OFS_PART_LO, 2);
    check(rd, {16'h0000, P_CODE[7:0], P_CODE[15:8]});
    rdn(scrb_pkg::OFS_MAKR_LO, 2);
    check(rd, {16'h0000, M_CODE[7:0], M_CODE[15:8]});
    rdn(scrb_pkg::OFS_USR, 1);
    check(rd, 32'h0000_0000);
    rdn(scrb_pkg::OFS_CLKC, 1);
    check(rd, 32'h0000_0000);
    // Writes to fixed fields and to an unmapped place are dropped
    oe_base = oe_cnt;
    wr1(scrb_pkg::OFS_TYPE, 8'hff);
    check(32'(oe_cnt), 32'(oe_base));
    rdn(scrb_pkg::OFS_TYPE, 1);
    check(rd, {24'h000000, 4'hf, T_CODE});
    wr1(scrb_pkg::OFS_PART_LO, 8'hff);
    rdn(scrb_pkg::OFS_PART_LO, 1);
    check(rd, {24'h000000, P_CODE[7:0]});
    wr1(15'h7ff0, 8'h5a);
    rdn(15'h7ff0, 1);
    check(rd, 32'h0000_0000);
    // Descending stream; the read marker survives a write of zero
    wr1(scrb_pkg::OFS_CFG, 8'h00);
    rdn(scrb_pkg::OFS_CFG, 1);
    check(rd, 32'h0000_0010);
    rdn(scrb_pkg::OFS_PART_HI, 2);
    check(rd, {16'h0000, P_CODE[15:8], P_CODE[7:0]});
    wr1(scrb_pkg::OFS_CFG, 8'h6f);
    rdn(scrb_pkg::OFS_CFG, 1);
    check(rd, 32'h0000_007f);
    // Every mode code
    for (int m = 0; m < 4; m++) begin
      wr1(scrb_pkg::OFS_MODE, {6'h00, 2'(m)});
      check({30'h0, op_mode}, 32'(m));
      check({31'h0, power_down}, {31'h0, m == 3});
    end
    // Held address: receiver first, then processor, into one register
    wr1(scrb_pkg::OFS_USR, 8'h01);
    scrb_host_inst.frame(1'b0, scrb_pkg::OFS_CLKC, 2, 32'h2075_0000, rd);
    check({24'h0, 1'b0, proc_en, recv_en, zoom, dly_sel}, 32'h0000_0075);
    rdn(scrb_pkg::OFS_USR, 2);
    check(rd, 32'h0000_0101);
    // Soft reset returns everything to reset values and clears itself
    wr1(scrb_pkg::OFS_CFG, 8'hb0);
    scrb_host_inst.settle();
    check(32'(rst_cnt), 32'(scrb_pkg::SOFT_RST_CYC));
    check({26'h0, proc_en, recv_en, op_mode, power_down, zoom}, 32'h0000_0000);
    rdn(scrb_pkg::OFS_CFG, 1);
    check(rd, 32'h0000_0030);
    rdn(scrb_pkg::OFS_USR, 1);
    check(rd, 32'h0000_0000);
    rdn(scrb_pkg::OFS_CLKC, 1);
    check(rd, 32'h0000_0000);
    close_out();
  end

endmodule

`default_nettype wire
